// ===== hdl/rom_emulator_lane_and_mode_control.sv
// ROM emulator lane mapping, mode control, target status and memory self-test
`timescale 1ns/10ps
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
// Overview of operation
// - Socket size accepted only as power of two
// - Part number needs 8/16-bit width, prefix 27/29
// - Report target powered and target accessing ROM
// - Status taken only from first master unit
// - Stop enters load mode, holds target reset
// - Auto-reset off stays off until session restart
// - Load mode disables target-side data buffers
// - Reset held from load entry until go
// - Self-test reports first failing address until cleared
// - Iterative unit pattern or 32-bit config pattern
// - Units addressed by 8-bit identifier
// - Default test: unit 0, one pass
// - Self-test overwrites emulation memory contents
// - Word width multiple of 8, within units
// - First listed unit holds lowest byte
// - Reset width 8, lanes ascending by identifier
// - Single-lane load beyond ROM flags overflow only after lane map write
// - Version query returns first unit firmware
// - ROM size within smallest unit memory
module rom_emulator_lane_and_mode_control #(
  parameter int units     = 4,
  parameter int addr_bits = 10
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [addr_bits-1:0] target_addr,
  input  wire logic                 target_read,
  input  wire logic                 target_power,
  output logic [units*8-1:0]        target_data,
  output logic [units-1:0]          target_data_oe,
  output logic                      target_reset
);
  initial begin
    if (units < 1 || units > 4)
      $error("units must be 1 to 4");
    if (addr_bits < 2 || addr_bits > 16)
      $error("addr_bits must be 2 to 16");
  end

  localparam int depth = 1 << addr_bits;

  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  logic [addr_bits-1:0] taddr_s1_r, taddr_s2_r;
  logic                 trd_s1_r, trd_s2_r, pwr_s1_r, pwr_s2_r;
  always_ff @(posedge clk) begin
    taddr_s1_r <= target_addr;
    taddr_s2_r <= taddr_s1_r;
    trd_s1_r   <= target_read;
    trd_s2_r   <= trd_s1_r;
    pwr_s1_r   <= target_power;
    pwr_s2_r   <= pwr_s1_r;
  end

  //------------------------------------------------------------
  // Bus handshake
  //------------------------------------------------------------
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        aw_have_r, w_have_r;
  logic        wr_fire, wr_map;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rom_emu_pkg::resp_okay;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? rom_emu_pkg::resp_okay : rom_emu_pkg::resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl, wr_word, wr_lane, wr_rom, wr_sock, wr_part, wr_test, wr_load;
  assign wr_ctrl = wr_fire && awaddr_r == rom_emu_pkg::ctrl_off;
  assign wr_word = wr_fire && awaddr_r == rom_emu_pkg::word_off;
  assign wr_lane = wr_fire && awaddr_r == rom_emu_pkg::lane_map_off;
  assign wr_rom  = wr_fire && awaddr_r == rom_emu_pkg::rom_size_off;
  assign wr_sock = wr_fire && awaddr_r == rom_emu_pkg::socket_off;
  assign wr_part = wr_fire && awaddr_r == rom_emu_pkg::part_off;
  assign wr_test = wr_fire && awaddr_r == rom_emu_pkg::test_off;
  assign wr_load = wr_fire && awaddr_r == rom_emu_pkg::load_off;
  assign wr_map  = wr_ctrl | wr_word | wr_lane | wr_rom | wr_sock | wr_part | wr_test | wr_load;

  //------------------------------------------------------------
  // Mode and target reset
  //------------------------------------------------------------
  logic load_mode_r, autorst_r, busy_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      load_mode_r <= 1'b1;
      autorst_r   <= 1'b1;
    end else begin
      if (wr_ctrl && wdata_r[rom_emu_pkg::ctrl_stop_bit])
        load_mode_r <= 1'b1;
      else if (wr_ctrl && wdata_r[rom_emu_pkg::ctrl_go_bit] && !busy_r)
        load_mode_r <= 1'b0;
      if (wr_ctrl && wdata_r[rom_emu_pkg::ctrl_session_bit])
        autorst_r <= 1'b1;
      else if (wr_ctrl && wdata_r[rom_emu_pkg::ctrl_noreset_bit])
        autorst_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      target_reset <= 1'b1;
    else
      target_reset <= load_mode_r && autorst_r;
  end

  //------------------------------------------------------------
  // Configuration: word width, lanes, sizes
  //------------------------------------------------------------
  logic [7:0]  word_bits_r;
  logic [31:0] lane_map_r;
  logic [31:0] rom_size_r, sock_size_r;
  logic        sizeerr_r, sockerr_r, parterr_r, worderr_r;
  logic [2:0]  lanes;
  logic        lane_given_r;
  assign lanes = word_bits_r[5:3];

  function automatic logic pow2(input logic [31:0] v);
    pow2 = v != 32'h0 && (v & (v - 32'h1)) == 32'h0;
  endfunction

  // Part prefix: digits above the last three
  logic [31:0] part_pfx;
  logic        part_ok;
  assign part_pfx = wdata_r / 32'd1000;
  assign part_ok  = (part_pfx == rom_emu_pkg::part_pfx_a || part_pfx == rom_emu_pkg::part_pfx_b)
                    && (word_bits_r == 8'd8 || word_bits_r == 8'd16);

  always_ff @(posedge clk) begin
    if (reset) begin
      word_bits_r  <= rom_emu_pkg::word_bits_rst;
      lane_map_r   <= 32'h03020100;
      lane_given_r <= 1'b0;
      rom_size_r   <= 32'(depth);
      sock_size_r  <= 32'(depth);
      sizeerr_r    <= 1'b0;
      sockerr_r    <= 1'b0;
      parterr_r    <= 1'b0;
      worderr_r    <= 1'b0;
    end else begin
      if (wr_word) begin
        if (wdata_r[2:0] == 3'b000 && wdata_r[7:0] != 8'h00 &&
            wdata_r[7:3] <= 5'(units)) begin
          word_bits_r <= wdata_r[7:0];
          worderr_r   <= 1'b0;
        end else begin
          worderr_r <= 1'b1;
        end
      end
      if (wr_lane) begin
        lane_map_r   <= wdata_r;
        lane_given_r <= 1'b1;
      end
      if (wr_rom) begin
        if (pow2(wdata_r) && wdata_r <= 32'(depth)) begin
          rom_size_r <= wdata_r;
          if (sock_size_r < wdata_r)
            sock_size_r <= wdata_r;
          sizeerr_r <= 1'b0;
        end else begin
          sizeerr_r <= 1'b1;
        end
      end
      if (wr_sock) begin
        if (pow2(wdata_r)) begin
          sock_size_r <= wdata_r;
          sockerr_r   <= 1'b0;
        end else begin
          sockerr_r <= 1'b1;
        end
      end
      if (wr_part) begin
        // Socket sized in words: kbits of the part over word width
        if (part_ok) begin
          sock_size_r <= (32'd128 << (wdata_r % 32'd1000 / 32'd10)) >> word_bits_r[4];
          parterr_r   <= 1'b0;
        end else begin
          parterr_r <= 1'b1;
        end
      end
    end
  end

  //------------------------------------------------------------
  // Emulation memory: one array per lane-unit, unit id indexed
  //------------------------------------------------------------
  logic [7:0] mem [units][depth];
  logic [7:0] rd_byte [units];
  logic       mem_we;
  logic [7:0] mem_wunit;
  logic [addr_bits-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [31:0] test_unit_sel;

  always_ff @(posedge clk) begin
    for (int u = 0; u < units; u++) begin
      if (mem_we && mem_wunit == 8'(u))
        mem[u][mem_waddr] <= mem_wdata;
      rd_byte[u] <= mem[u][taddr_s2_r];
    end
  end

  // Lane of each unit: its position in the map, or unit id by default
  logic trd_d_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      target_data    <= '0;
      target_data_oe <= '0;
      trd_d_r        <= 1'b0;
    end else begin
      trd_d_r <= trd_s2_r;
      for (int l = 0; l < units; l++) begin
        target_data[l*8 +: 8] <= rd_byte[lane_map_r[l*8 +: 2]];
        target_data_oe[l]     <= !load_mode_r && trd_d_r && 3'(l) < lanes;
      end
    end
  end

  //------------------------------------------------------------
  // Load port: byte write with overflow check
  //------------------------------------------------------------
  logic        ovf_r;
  logic [31:0] load_byte_addr;
  logic [1:0]  load_lane;
  assign load_byte_addr = {8'h00, wdata_r[31:8]};
  assign load_lane = 2'(load_byte_addr % 32'(lanes));

  always_ff @(posedge clk) begin
    if (reset)
      ovf_r <= 1'b0;
    else if (wr_load && load_mode_r)
      ovf_r <= load_byte_addr / 32'(lanes) >= rom_size_r && (lane_given_r || lanes > 3'd1);
  end

  //------------------------------------------------------------
  // Memory self-test
  //------------------------------------------------------------
  rom_emu_pkg::test_state_t tstate_r;
  logic [7:0]           tunit_r, tpass_r;
  logic                 tcfg_r, fail_r, failv_r;
  logic [addr_bits-1:0] taddr_r;
  logic [1:0]           tlane_r;
  logic [31:0]          pat_r, pat_base_r, fail_addr_r;
  logic [7:0]           expect_byte, got_byte;
  logic                 last_loc;

  assign busy_r = tstate_r != rom_emu_pkg::t_idle;
  assign last_loc = taddr_r == '1 && (!tcfg_r || tlane_r == 2'(lanes - 3'd1));
  assign test_unit_sel = tcfg_r ? 32'(lane_map_r[tlane_r*8 +: 8]) : 32'(tunit_r);
  // Unit pattern iterates on address and pass; config pattern is an LFSR
  assign expect_byte = tcfg_r ? pat_r[7:0] : 8'(taddr_r) ^ tpass_r;
  assign got_byte = mem[test_unit_sel[1:0]][taddr_r];

  always_ff @(posedge clk) begin
    if (reset) begin
      tstate_r    <= rom_emu_pkg::t_idle;
      tunit_r     <= rom_emu_pkg::test_unit_rst;
      tpass_r     <= rom_emu_pkg::test_pass_rst;
      tcfg_r      <= 1'b0;
      taddr_r     <= '0;
      tlane_r     <= 2'b00;
      pat_r       <= rom_emu_pkg::lfsr_seed;
      pat_base_r  <= rom_emu_pkg::lfsr_seed;
      fail_r      <= 1'b0;
      failv_r     <= 1'b0;
      fail_addr_r <= 32'h0;
    end else begin
      if (wr_fire && awaddr_r == rom_emu_pkg::fail_off)
        failv_r <= 1'b0;
      case (tstate_r)
        rom_emu_pkg::t_idle: begin
          if (wr_test && wdata_r[rom_emu_pkg::test_start_bit] && load_mode_r) begin
            tcfg_r  <= wdata_r[rom_emu_pkg::test_cfg_bit];
            tunit_r <= wdata_r[rom_emu_pkg::test_unit_lsb +: 8];
            tpass_r <= wdata_r[rom_emu_pkg::test_pass_lsb +: 8] == 8'h00 ?
                       rom_emu_pkg::test_pass_rst : wdata_r[rom_emu_pkg::test_pass_lsb +: 8];
            fail_r   <= 1'b0;
            taddr_r  <= '0;
            tlane_r  <= 2'b00;
            pat_r    <= pat_base_r;
            tstate_r <= (wdata_r[rom_emu_pkg::test_unit_lsb +: 8] < 8'(units) ||
                         wdata_r[rom_emu_pkg::test_cfg_bit]) ?
                        rom_emu_pkg::t_write : rom_emu_pkg::t_done;
            if (!(wdata_r[rom_emu_pkg::test_unit_lsb +: 8] < 8'(units) ||
                  wdata_r[rom_emu_pkg::test_cfg_bit]))
              fail_r <= 1'b1;
          end
        end
        rom_emu_pkg::t_write, rom_emu_pkg::t_read: begin
          pat_r <= {pat_r[30:0], ^(pat_r & rom_emu_pkg::lfsr_taps)};
          if (tstate_r == rom_emu_pkg::t_read && got_byte != expect_byte && !failv_r) begin
            fail_r      <= 1'b1;
            failv_r     <= 1'b1;
            fail_addr_r <= {6'h00, tlane_r, 8'(test_unit_sel), 16'(taddr_r)};
          end
          if (tcfg_r && tlane_r != 2'(lanes - 3'd1)) begin
            tlane_r <= tlane_r + 2'b01;
          end else begin
            tlane_r <= 2'b00;
            taddr_r <= taddr_r + 1'b1;
          end
          if (last_loc) begin
            if (tstate_r == rom_emu_pkg::t_write) begin
              pat_r    <= pat_base_r;
              tstate_r <= rom_emu_pkg::t_read;
            end else begin
              pat_base_r <= {pat_r[30:0], ^(pat_r & rom_emu_pkg::lfsr_taps)};
              tpass_r    <= tpass_r - 8'h01;
              tstate_r   <= tpass_r == 8'h01 ? rom_emu_pkg::t_done : rom_emu_pkg::t_write;
            end
          end
        end
        rom_emu_pkg::t_done: tstate_r <= rom_emu_pkg::t_idle;
        default: tstate_r <= rom_emu_pkg::t_idle;
      endcase
    end
  end

  // Shared memory write port: test writes, or host load writes
  always_comb begin
    mem_we    = 1'b0;
    mem_wunit = 8'h00;
    mem_waddr = '0;
    mem_wdata = 8'h00;
    if (tstate_r == rom_emu_pkg::t_write) begin
      mem_we    = 1'b1;
      mem_wunit = 8'(test_unit_sel);
      mem_waddr = taddr_r;
      mem_wdata = expect_byte;
    end else if (wr_load && load_mode_r && !busy_r) begin
      mem_we    = load_byte_addr / 32'(lanes) < rom_size_r;
      mem_wunit = lane_map_r[load_lane*8 +: 8];
      mem_waddr = addr_bits'(load_byte_addr / 32'(lanes));
      mem_wdata = wdata_r[7:0];
    end
  end

  //------------------------------------------------------------
  // Read side
  //------------------------------------------------------------
  logic [31:0] status_word, rd_mux;
  logic        rd_ok;
  always_comb begin
    status_word = 32'h0;
    status_word[rom_emu_pkg::st_power_bit]   = pwr_s2_r;
    status_word[rom_emu_pkg::st_access_bit]  = trd_s2_r && pwr_s2_r;
    status_word[rom_emu_pkg::st_load_bit]    = load_mode_r;
    status_word[rom_emu_pkg::st_autorst_bit] = autorst_r;
    status_word[rom_emu_pkg::st_busy_bit]    = busy_r;
    status_word[rom_emu_pkg::st_fail_bit]    = fail_r;
    status_word[rom_emu_pkg::st_sizeerr_bit] = sizeerr_r;
    status_word[rom_emu_pkg::st_sockerr_bit] = sockerr_r;
    status_word[rom_emu_pkg::st_parterr_bit] = parterr_r;
    status_word[rom_emu_pkg::st_worderr_bit] = worderr_r;
    status_word[rom_emu_pkg::st_ovf_bit]     = ovf_r;
    status_word[rom_emu_pkg::st_failv_bit]   = failv_r;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      rom_emu_pkg::ctrl_off:     rd_mux = 32'h0;
      rom_emu_pkg::word_off:     rd_mux = {24'h0, word_bits_r};
      rom_emu_pkg::lane_map_off: rd_mux = lane_map_r;
      rom_emu_pkg::rom_size_off: rd_mux = rom_size_r;
      rom_emu_pkg::socket_off:   rd_mux = sock_size_r;
      rom_emu_pkg::test_off:     rd_mux = {8'h0, tpass_r, tunit_r, 6'h0, tcfg_r, busy_r};
      rom_emu_pkg::status_off:   rd_mux = status_word;
      rom_emu_pkg::fail_off:     rd_mux = fail_addr_r;
      rom_emu_pkg::version_off:  rd_mux = rom_emu_pkg::fw_version;
      default: begin
        rd_mux = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= rom_emu_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? rom_emu_pkg::resp_okay : rom_emu_pkg::resp_slverr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== hdl/rom_emu_pkg.sv
// Register map, fields, reset values and limits of the ROM emulator control
package rom_emu_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off      = 8'h00;
  localparam logic [7:0] word_off      = 8'h04;
  localparam logic [7:0] lane_map_off  = 8'h08;
  localparam logic [7:0] rom_size_off  = 8'h0c;
  localparam logic [7:0] socket_off    = 8'h10;
  localparam logic [7:0] part_off      = 8'h14;
  localparam logic [7:0] test_off      = 8'h18;
  localparam logic [7:0] status_off    = 8'h1c;
  localparam logic [7:0] fail_off      = 8'h20;
  localparam logic [7:0] version_off   = 8'h24;
  localparam logic [7:0] load_off      = 8'h28;
  // Control register bits (write 1 strobes)
  localparam int ctrl_stop_bit    = 0;
  localparam int ctrl_go_bit      = 1;
  localparam int ctrl_noreset_bit = 2;
  localparam int ctrl_session_bit = 3;
  // Test register fields
  localparam int test_start_bit   = 0;
  localparam int test_cfg_bit     = 1;
  localparam int test_unit_lsb    = 8;
  localparam int test_pass_lsb    = 16;
  // Status register bits
  localparam int st_power_bit     = 0;
  localparam int st_access_bit    = 1;
  localparam int st_load_bit      = 2;
  localparam int st_autorst_bit   = 3;
  localparam int st_busy_bit      = 4;
  localparam int st_fail_bit      = 5;
  localparam int st_sizeerr_bit   = 6;
  localparam int st_sockerr_bit   = 7;
  localparam int st_parterr_bit   = 8;
  localparam int st_worderr_bit   = 9;
  localparam int st_ovf_bit       = 10;
  localparam int st_failv_bit     = 11;
  // Reset values
  localparam logic [7:0]  word_bits_rst = 8'h08;
  localparam logic [7:0]  test_unit_rst = 8'h00;
  localparam logic [7:0]  test_pass_rst = 8'h01;
  // Accepted part-number prefixes
  localparam logic [31:0] part_pfx_a    = 32'h0000001b;
  localparam logic [31:0] part_pfx_b    = 32'h0000001d;
  // Arbitrary firmware version code
  localparam logic [31:0] fw_version    = 32'h00000100;
  // Pattern generator seed and taps
  localparam logic [31:0] lfsr_seed     = 32'h00000001;
  localparam logic [31:0] lfsr_taps     = 32'h80200003;
  // Bus responses
  localparam logic [1:0]  resp_okay     = 2'b00;
  localparam logic [1:0]  resp_slverr   = 2'b10;
  typedef enum logic [1:0] {t_idle, t_write, t_read, t_done} test_state_t;
endpackage

// ===== bench/rom_emu_sva.sv
// Port checker for the ROM emulator lane and mode control
`timescale 1ns/10ps
module rom_emu_sva #(
  parameter int units     = 4,
  parameter int addr_bits = 10
) (
  input wire logic             clk, reset, target_read, target_reset,
  input wire logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic             s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]       s_axi_bresp, s_axi_rresp,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [units-1:0] target_data_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
  property p_b_after; s_aw ##0 s_w |-> ##[1:2] s_axi_bvalid; endproperty
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rst; disable iff (1'b0) reset |=> target_reset && target_data_oe == '0;
  endproperty
  property p_buf_off; target_reset && $past(target_reset) |-> target_data_oe == '0;
  endproperty
  property p_oe_read; $rose(target_data_oe[0]) |-> $past(target_read) ||
    $past(target_read, 2) || $past(target_read, 3) || $past(target_read, 4); endproperty
  property p_lanes; ((target_data_oe + 1'b1) & target_data_oe) == '0; endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  a_r_after: assert property (p_r_after) else $error("read data late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_b_busy: assert property (p_b_busy) else $error("ready while response held");
  a_rst: assert property (p_rst) else $error("reset not in load mode");
  a_buf_off: assert property (p_buf_off) else $error("buffers on in load mode");
  a_oe_read: assert property (p_oe_read) else $error("lane driven without read");
  a_lanes: assert property (p_lanes) else $error("lanes not from lowest up");
endmodule
bind rom_emulator_lane_and_mode_control rom_emu_sva #(.units(units), .addr_bits(addr_bits))
  i_rom_emu_sva (.*);

// ===== bench/target_model.sv
// Target processor model reading the emulated ROM socket
`timescale 1ns/10ps
module target_model (
  input  wire logic        clk,
  output logic [9:0]       target_addr,
  output logic             target_read,
  output logic             target_power,
  input  wire logic [31:0] target_data,
  input  wire logic [3:0]  target_data_oe
);
  initial begin
    target_addr = '1;
    target_read = 1'b0;
    target_power = 1'b1;
  end
  task automatic set_power(input logic p);
    @(posedge clk);
    target_power <= p;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [3:0] oe);
    @(posedge clk);
    target_addr <= a;
    target_read <= 1'b1;
    repeat (8) @(posedge clk);
    d = target_data;
    oe = target_data_oe;
    target_read <= 1'b0;
    target_addr <= ~a;
  endtask
endmodule

// ===== bench/tb.sv
// Self-checking bench for the ROM emulator lane and mode control
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, target_data, seed, v, x, ex, d;
  logic [3:0]  s_axi_wstrb, target_data_oe, oe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [9:0]  target_addr;
  logic        target_read, target_power, target_reset;
  int          n_fail = 0;
  int          check_count = 0;
  localparam logic [31:0] sz_v [5] = '{32'h800, 32'h400, 32'hc, 32'h28, 32'h10};
  localparam logic [31:0] ctl_v [4] = '{32'h4, 32'h2, 32'h1, 32'h8};
  always #4 clk = ~clk;
  rom_emulator_lane_and_mode_control i_rom_emulator_lane_and_mode_control (.*);
  target_model i_target_model (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic pow2(input logic [31:0] s);
    return s != 0 && (s & (s - 1)) == 0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic st(input int b, input logic e);
    rd(rom_emu_pkg::status_off);
    chk("status bit", {31'h0, e}, {31'h0, v[b]});
  endtask
  task automatic wait_test;
    do rd(rom_emu_pkg::status_off); while (v[rom_emu_pkg::st_busy_bit]);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    seed = 32'he80ff3c3;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(rom_emu_pkg::word_off);
    chk("word", 32'h8, v);
    chk("reset out", 32'h1, {31'h0, target_reset});
    rd(rom_emu_pkg::lane_map_off);
    chk("lane map", 32'h03020100, v);
    rd(rom_emu_pkg::version_off);
    chk("version", rom_emu_pkg::fw_version, v);
    rd(8'h30);
    chk("unmapped read", {30'h0, rom_emu_pkg::resp_slverr}, {30'h0, r});
    st(rom_emu_pkg::st_load_bit, 1'b1);
    st(rom_emu_pkg::st_autorst_bit, 1'b1);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      x = (k == 0) ? '0 : seed[8] ? 32'h1 << seed[4:0] : {20'h0, seed[11:0]};
      wr(rom_emu_pkg::socket_off, x);
      st(rom_emu_pkg::st_sockerr_bit, !pow2(x));
    end
    foreach (sz_v[k]) begin
      x = sz_v[k];
      wr(k < 2 ? rom_emu_pkg::rom_size_off : rom_emu_pkg::word_off, x);
      if (k < 2) st(rom_emu_pkg::st_sizeerr_bit, x > 32'h400);
      else st(rom_emu_pkg::st_worderr_bit, x[2:0] != 0 || x > 32'h20);
    end
    wr(rom_emu_pkg::part_off, 32'h000069a0);
    st(rom_emu_pkg::st_parterr_bit, 1'b0);
    rd(rom_emu_pkg::socket_off);
    chk("part socket", 32'h400, v);
    wr(rom_emu_pkg::part_off, 32'h00006d6a);
    st(rom_emu_pkg::st_parterr_bit, 1'b1);
    wr(rom_emu_pkg::word_off, 32'h18);
    wr(rom_emu_pkg::part_off, 32'h00007152);
    st(rom_emu_pkg::st_parterr_bit, 1'b1);
    i_target_model.set_power(1'b0);
    repeat (4) @(posedge clk);
    st(rom_emu_pkg::st_power_bit, 1'b0);
    i_target_model.set_power(1'b1);
    repeat (4) @(posedge clk);
    st(rom_emu_pkg::st_power_bit, 1'b1);
    $display("config test done");
    wr(rom_emu_pkg::test_off, 32'h1);
    rd(rom_emu_pkg::test_off);
    chk("test default", 32'h00010001, v);
    wait_test();
    st(rom_emu_pkg::st_fail_bit, 1'b0);
    wr(rom_emu_pkg::test_off, 32'h00020003);
    wait_test();
    rd(rom_emu_pkg::test_off);
    chk("test config", 32'h00000002, v);
    st(rom_emu_pkg::st_fail_bit, 1'b0);
    wr(rom_emu_pkg::test_off, 32'h0001c801);
    wait_test();
    st(rom_emu_pkg::st_fail_bit, 1'b1);
    st(rom_emu_pkg::st_failv_bit, 1'b0);
    $display("self test done");
    wr(rom_emu_pkg::word_off, 32'h20);
    wr(rom_emu_pkg::lane_map_off, 32'h01000302);
    for (int b = 0; b < 4; b++) begin
      seed = lfsr(seed);
      ex[b*8+:8] = seed[7:0];
      wr(rom_emu_pkg::load_off, {24'(b), seed[7:0]});
    end
    wr(rom_emu_pkg::load_off, 32'h00100000);
    st(rom_emu_pkg::st_ovf_bit, 1'b1);
    wr(rom_emu_pkg::ctrl_off, 32'h2);
    i_target_model.rd(10'h0, d, oe);
    chk("lane enables", 32'hf, {28'h0, oe});
    chk("lane bytes", ex, d);
    chk("reset out", 32'h0, {31'h0, target_reset});
    wr(rom_emu_pkg::ctrl_off, 32'h1);
    i_target_model.rd(10'h0, d, oe);
    chk("load enables", 32'h0, {28'h0, oe});
    chk("reset out", 32'h1, {31'h0, target_reset});
    foreach (ctl_v[k]) begin
      wr(rom_emu_pkg::ctrl_off, ctl_v[k]);
      repeat (3) @(posedge clk);
      if (k != 1) chk("reset out", {31'h0, k == 3}, {31'h0, target_reset});
    end
    $display("mode test done");
    give_verdict();
  end
endmodule
